// ===== sim/crs_flash_model.sv
`timescale 1ns/100ps
// serial flash: counts clocked bits, keeps the command, returns a pattern
module crs_flash_model (
  input  wire logic flash_serial_clock_i,
  input  wire logic flash_chip_select_i,
  input  wire logic flash_serial_out_i,
  output logic      flash_serial_in_o,
  output logic [7:0] cmd_o,
  output int        bits_o
);
  logic [7:0] pat = 8'ha5;  // rotating read data
  initial cmd_o = 8'h00;
  initial bits_o = 0;
  initial flash_serial_in_o = 1'b0;
  // capture the first byte while selected
  always @(posedge flash_serial_clock_i) begin
    if (!flash_chip_select_i) begin
      if (bits_o < 8) cmd_o <= {cmd_o[6:0], flash_serial_out_i};
      bits_o <= bits_o + 1;
    end
  end
  // data after the address; a released line shows the inverse of its last bit
  always @(negedge flash_serial_clock_i or posedge flash_chip_select_i) begin
    if (flash_chip_select_i) flash_serial_in_o <= !flash_serial_in_o;
    else if (bits_o > 31) begin
      flash_serial_in_o <= pat[7];
      pat <= {pat[6:0], pat[7]};
    end
  end
endmodule

// ===== sim/crs_seq_properties.sv
`timescale 1ns/100ps
// pin-level checks on the sequencer
module crs_seq_properties #(
  parameter int unsigned PARK_CYCLES = 20
) (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       pll_lock_i,
  input wire logic       power_good_i,
  input wire logic       i2c_cfg_strobe_i,
  input wire logic [7:0] i2c_cfg_data_i,
  input wire logic       init_flag_o,
  input wire logic       mirror_power_enable_o,
  input wire logic       mirror_power_enable_oe_n_o,
  input wire logic       led_oe_n_o,
  input wire logic       flash_oe_n_o,
  input wire logic       flash_chip_select_o,
  input wire logic       parked_o,
  input wire logic [7:0] cfg_word_o,
  input wire logic       cfg_ready_o
);
  logic [15:0] lo_run;  // cycles the warning has stayed low
  ////////////////////////////////////////////////////////////
  // saturating count of the low run
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) lo_run <= 16'h0000;
    else if (power_good_i) lo_run <= 16'h0000;
    else if (lo_run != 16'hffff) lo_run <= lo_run + 16'h0001;
  end
  a_float_reset: assert property (@(posedge clk_sys_i) reset_i |->
    mirror_power_enable_oe_n_o && led_oe_n_o && flash_oe_n_o) else $error("pin driven in reset");
  a_idle_reset: assert property (@(posedge clk_sys_i) reset_i |->
    !init_flag_o && !parked_o && flash_chip_select_o) else $error("output active in reset");
  a_flag_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(reset_i) |-> !init_flag_o ##[1:4] init_flag_o) else $error("busy flag late");
  a_pins_live: assert property (@(posedge clk_sys_i) disable iff (reset_i) init_flag_o |->
    !mirror_power_enable_oe_n_o && !led_oe_n_o && !flash_oe_n_o) else $error("pin floats");
  a_lock_first: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(flash_chip_select_o) |-> $past(pll_lock_i)) else $error("load before lock");
  a_load_done: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(init_flag_o) |-> flash_chip_select_o) else $error("flag low during load");
  a_park_time: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(parked_o) |-> lo_run >= PARK_CYCLES && lo_run <= PARK_CYCLES + 7)
    else $error("park length wrong");
  a_park_due: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    lo_run == PARK_CYCLES + 8 |-> parked_o && !mirror_power_enable_o) else $error("not parked");
  a_cfg_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    i2c_cfg_strobe_i && cfg_ready_o |=> cfg_word_o == $past(i2c_cfg_data_i))
    else $error("config byte lost");
endmodule

// ===== sim/crs_sequencer_tb_top.sv
`timescale 1ns/100ps
module crs_sequencer_tb_top;
  localparam int unsigned PARK = 20;  // shortened park time
  localparam int unsigned WORDS = 2;  // shortened flash image
  logic clk_sys_i, reset_i, pll_lock_i, power_good_i, stb, fin;
  logic [7:0] data, word, cmd;
  logic flag, mp, mp_oe_n, led, l0, l1, led_oe_n, fclk, fout, fcs, f_oe_n, parked, rdy;
  int bits, fail_count = 0, n_compared = 0;
  wire cs_w = f_oe_n ? 1'b1 : fcs;    // pulled up when floated
  wire clk_w = f_oe_n ? 1'b0 : fclk;  // pulled down when floated
  crs_sequencer #(.CFG_WORDS(WORDS), .PARK_CYCLES(PARK)) dut (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .pll_lock_i(pll_lock_i), .power_good_i(power_good_i),
    .flash_serial_in_i(fin), .i2c_cfg_strobe_i(stb), .i2c_cfg_data_i(data),
    .init_flag_o(flag), .mirror_power_enable_o(mp), .mirror_power_enable_oe_n_o(mp_oe_n),
    .led_driver_enable_o(led), .led_select_0_o(l0), .led_select_1_o(l1),
    .led_oe_n_o(led_oe_n), .flash_serial_clock_o(fclk), .flash_serial_out_o(fout),
    .flash_chip_select_o(fcs), .flash_oe_n_o(f_oe_n), .parked_o(parked),
    .cfg_word_o(word), .cfg_ready_o(rdy));
  crs_flash_model flash (.flash_serial_clock_i(clk_w), .flash_chip_select_i(cs_w),
    .flash_serial_out_i(fout), .flash_serial_in_o(fin), .cmd_o(cmd), .bits_o(bits));
  always #50 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hold reset five cycles, pins must float
  task automatic t_reset();
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #10;
    chk("float", {5'h00, mp_oe_n, led_oe_n, f_oe_n}, 8'h07);
    chk("idle", {5'h00, flag, parked, fcs}, 8'h01);
    $display("reset test ended");
  endtask
  // release without lock, then lock and load
  task automatic t_init();
    power_good_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #10;
    chk("busy", {6'h00, flag, cs_w}, 8'h03);
    chk("live", {5'h00, mp_oe_n, led_oe_n, f_oe_n}, 8'h00);
    pll_lock_i <= 1'b1;
    for (int i = 0; i < 3000 && flag !== 1'b0; i++) @(posedge clk_sys_i);
    #10;
    chk("done", {7'h00, flag}, 8'h00);
    chk("cmd", cmd, crs_pkg::FLASH_READ_CMD);
    chk("bits", 8'(bits), 8'(32 + WORDS * 8));
    chk("image", word, 8'ha5);
    chk("run pins", {4'h0, mp, led, l1, l0}, 8'h0d);
    $display("init test ended");
  endtask
  // host writes two bytes back to back once ready
  task automatic t_cfg();
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk_sys_i);
    chk("ready", {7'h00, rdy}, 8'h01);
    @(posedge clk_sys_i);
    stb <= 1'b1;
    data <= 8'h5a;
    @(posedge clk_sys_i);
    data <= 8'hc3;
    #10;
    chk("cfg1", word, 8'h5a);
    @(posedge clk_sys_i);
    stb <= 1'b0;
    #10;
    chk("cfg2", word, 8'hc3);
    @(posedge clk_sys_i);
    #10;
    chk("sel", {6'h00, l1, l0}, 8'h03);
    $display("config test ended");
  endtask
  // a 100 ns dip must not park
  task automatic t_glitch();
    @(posedge clk_sys_i);
    power_good_i <= 1'b0;
    @(posedge clk_sys_i);
    power_good_i <= 1'b1;
    repeat (PARK + 10) @(posedge clk_sys_i);
    #10;
    chk("glitch", {7'h00, parked}, 8'h00);
    $display("glitch test ended");
  endtask
  // warning held low, clock and reset kept
  task automatic t_park();
    @(posedge clk_sys_i);
    power_good_i <= 1'b0;
    for (int i = 0; i < PARK + 40 && parked !== 1'b1; i++) @(posedge clk_sys_i);
    repeat (12) @(posedge clk_sys_i);
    #10;
    chk("park", {4'h0, parked, mp, led, rdy}, 8'h08);
    // a host write while parked must be ignored
    @(posedge clk_sys_i);
    stb <= 1'b1;
    data <= 8'h3c;
    @(posedge clk_sys_i);
    stb <= 1'b0;
    @(posedge clk_sys_i);
    #10;
    chk("refused", word, 8'hc3);
    $display("park test ended");
  endtask
  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b0;
    pll_lock_i = 1'b0;
    power_good_i = 1'b1;
    stb = 1'b0;
    data = 8'h00;
    // a real rising edge on reset once every process waits for it
    #1;
    t_reset();
    t_init();
    t_cfg();
    t_glitch();
    t_park();
    t_reset();
    summarize();
  end
  // watchdog well past the expected run
  initial begin
    #3000000;
    fail_count++;
    summarize();
  end
endmodule
bind crs_sequencer crs_seq_properties #(.PARK_CYCLES(PARK_CYCLES)) u_props (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pll_lock_i(pll_lock_i),
  .power_good_i(power_good_i), .i2c_cfg_strobe_i(i2c_cfg_strobe_i),
  .i2c_cfg_data_i(i2c_cfg_data_i), .init_flag_o(init_flag_o),
  .mirror_power_enable_o(mirror_power_enable_o), .led_oe_n_o(led_oe_n_o),
  .mirror_power_enable_oe_n_o(mirror_power_enable_oe_n_o), .flash_oe_n_o(flash_oe_n_o),
  .flash_chip_select_o(flash_chip_select_o), .parked_o(parked_o),
  .cfg_word_o(cfg_word_o), .cfg_ready_o(cfg_ready_o));

// ===== src/crs_glitch_filter.sv
`timescale 1ns/100ps
// debounce for a slow-edged input: output follows only a level that held steady
module crs_glitch_filter #(
  parameter int unsigned STABLE_CYCLES = 2
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  output logic      filtered_o
);

  logic [7:0] count;   // cycles the raw level has differed from output
  logic       differ;  // raw level disagrees with filtered output
  logic       accept;  // the new level is trusted

  assign differ = raw_i != filtered_o;
  assign accept = differ && (count >= 8'(STABLE_CYCLES - 1));

  // count stable disagreement, reset on any agreement
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count      <= 8'h00;
      filtered_o <= 1'b1;
    end else begin
      count      <= (differ && !accept) ? count + 8'h01 : 8'h00;
      if (accept) begin
        filtered_o <= raw_i;
      end
    end
  end

endmodule

// ===== src/crs_pkg.sv
package crs_pkg;

  // clock rate in kHz (10 MHz system clock)
  localparam int unsigned CLK_KHZ            = 10000;
  // glitch filter on the power-good warning, in ns
  localparam int unsigned PG_GLITCH_NS       = 150;
  // cycles a new level must hold before it is believed (150 ns at 10 MHz -> 1, plus one)
  localparam int unsigned PG_FILTER_CYCLES   = (PG_GLITCH_NS * CLK_KHZ) / 1000000 + 1;
  // park operation length in us (host guarantees clock and reset for this time)
  localparam int unsigned PARK_TIME_US       = 500;
  // longest time rounds down
  localparam int unsigned PARK_CYCLES        = (PARK_TIME_US * CLK_KHZ) / 1000;
  // reset release synchroniser depth
  localparam int unsigned RST_SYNC_STAGES    = 2;
  // default words of self-configuration loaded from flash
  localparam int unsigned CFG_WORDS_DEFAULT  = 16;
  // serial flash read command
  localparam logic [7:0]  FLASH_READ_CMD     = 8'h03;
  // value of the initialization flag after reset release
  localparam logic        INIT_FLAG_BUSY     = 1'b1;

  // initialization / park sequencer states
  typedef enum logic [2:0] {
    CRS_ST_RESET,
    CRS_ST_PLL_WAIT,
    CRS_ST_FLASH_LOAD,
    CRS_ST_RUN,
    CRS_ST_PARKING,
    CRS_ST_PARKED
  } crs_state_type;

endpackage

// ===== src/crs_sequencer.sv
`timescale 1ns/100ps
// Operation
// - in reset outputs inactive, bidirectionals input
// - listed enables and flash outputs float in reset
// - after reset: pll lock, then flash load
// - reset release activates all pins
// - init flag high while busy, low done
// - warning low triggers mirror park
// - warning input filtered against 150 ns glitches
// - configuration arrives over I2C
module crs_sequencer #(
  parameter int unsigned CFG_WORDS   = crs_pkg::CFG_WORDS_DEFAULT,
  parameter int unsigned PARK_CYCLES = crs_pkg::PARK_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,            // async, active high (pin is low-active)
  input  wire logic       pll_lock_i,         // internal pll locked
  input  wire logic       power_good_i,       // early warning, low means supplies failing
  input  wire logic       flash_serial_in_i,  // serial flash data in
  input  wire logic       i2c_cfg_strobe_i,   // host configuration write over I2C
  input  wire logic [7:0] i2c_cfg_data_i,     // host configuration byte
  output logic            init_flag_o,        // high while auto-initialization runs
  output logic            mirror_power_enable_o,
  output logic            mirror_power_enable_oe_n_o,
  output logic            led_driver_enable_o,
  output logic            led_select_0_o,
  output logic            led_select_1_o,
  output logic            led_oe_n_o,         // shared enable of led outputs
  output logic            flash_serial_clock_o,
  output logic            flash_serial_out_o,
  output logic            flash_chip_select_o,
  output logic            flash_oe_n_o,       // shared enable of flash outputs
  output logic            parked_o,           // mirror array parked
  output logic [7:0]      cfg_word_o,         // last configuration byte accepted
  output logic            cfg_ready_o         // configuration may be accepted
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser

  logic [crs_pkg::RST_SYNC_STAGES-1:0] rst_sync;  // shift in ones after release
  logic                                run_rst;   // synchronised internal reset

  // assert at once, release on clock
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[crs_pkg::RST_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign run_rst = !rst_sync[crs_pkg::RST_SYNC_STAGES-1];

  //////////////////////////////////////////////////////////////////////////////
  // power-good warning filter

  logic pg_filt; // filtered warning level

  crs_glitch_filter #(
    .STABLE_CYCLES (crs_pkg::PG_FILTER_CYCLES)
  ) u_pg_filter (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (run_rst),
    .raw_i      (power_good_i),
    .filtered_o (pg_filt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state and counters

  crs_pkg::crs_state_type state;       // sequencer state
  crs_pkg::crs_state_type next_state;  // next sequencer state
  logic [15:0]            bit_cnt;     // flash bit counter
  logic [19:0]            park_cnt;    // park timer
  logic                   pg_fall;     // filtered warning dropped
  logic                   pg_prev;     // last filtered warning level
  logic                   load_done;   // every config bit shifted in
  logic                   park_done;   // park time elapsed
  logic                   sclk_phase;  // second half of a flash bit, serial clock set high at its end

  localparam logic [15:0] LOAD_BITS = 16'(8 + 24 + CFG_WORDS * 8); // cmd, addr, data

  assign pg_fall   = pg_prev && !pg_filt;
  assign load_done = bit_cnt == LOAD_BITS;
  assign park_done = park_cnt == 20'(PARK_CYCLES - 1);

  // next state: pll lock, then flash load, then run; park overrides
  always_comb begin
    next_state = state;
    case (state)
      crs_pkg::CRS_ST_RESET:      next_state = crs_pkg::CRS_ST_PLL_WAIT;
      crs_pkg::CRS_ST_PLL_WAIT: begin
        if (pll_lock_i) begin
          next_state = crs_pkg::CRS_ST_FLASH_LOAD;
        end
      end
      crs_pkg::CRS_ST_FLASH_LOAD: begin
        if (load_done) begin
          next_state = crs_pkg::CRS_ST_RUN;
        end
      end
      crs_pkg::CRS_ST_RUN:        next_state = state;
      crs_pkg::CRS_ST_PARKING: begin
        if (park_done) begin
          next_state = crs_pkg::CRS_ST_PARKED;
        end
      end
      crs_pkg::CRS_ST_PARKED:     next_state = state;
      default:                    next_state = crs_pkg::CRS_ST_RESET;
    endcase
    if (pg_fall && state != crs_pkg::CRS_ST_PARKING && state != crs_pkg::CRS_ST_PARKED) begin
      next_state = crs_pkg::CRS_ST_PARKING;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge run_rst) begin
    if (run_rst) begin
      state   <= crs_pkg::CRS_ST_RESET;
      pg_prev <= 1'b1;
    end else begin
      state   <= next_state;
      pg_prev <= pg_filt;
    end
  end

  // flash bit and park counters
  always_ff @(posedge clk_sys_i or posedge run_rst) begin
    if (run_rst) begin
      sclk_phase <= 1'b0;
      bit_cnt    <= 16'h0000;
      park_cnt   <= 20'h00000;
    end else begin
      // one flash bit spans two cycles: serial clock low, then high
      sclk_phase <= (state == crs_pkg::CRS_ST_FLASH_LOAD && !load_done) ? !sclk_phase : 1'b0;
      bit_cnt    <= (state == crs_pkg::CRS_ST_FLASH_LOAD && !load_done && sclk_phase) ?
                    bit_cnt + 16'h0001 : bit_cnt;
      park_cnt   <= (state == crs_pkg::CRS_ST_PARKING) ? park_cnt + 20'h00001 : 20'h00000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial flash read: command, zero address, then configuration bits

  logic       loading;      // flash transfer active
  logic [7:0] cmd_bit_sel;  // command bit index
  logic       next_sdo;     // next serial data bit
  logic [7:0] cfg_shift;    // incoming configuration byte

  assign loading     = state == crs_pkg::CRS_ST_FLASH_LOAD && !load_done;
  assign cmd_bit_sel = 8'(7 - bit_cnt[2:0]);
  assign next_sdo    = (bit_cnt < 16'h0008) ? crs_pkg::FLASH_READ_CMD[cmd_bit_sel[2:0]] :
                       1'b0;

  // drive flash pins, shift in self-configuration data
  always_ff @(posedge clk_sys_i or posedge run_rst) begin
    if (run_rst) begin
      flash_serial_clock_o <= 1'b0;
      flash_serial_out_o   <= 1'b0;
      flash_chip_select_o  <= 1'b1;
      cfg_shift            <= 8'h00;
    end else begin
      flash_chip_select_o  <= !loading;
      flash_serial_out_o   <= loading ? next_sdo : 1'b0;
      // serial clock toggles at half rate so the flash sees one rising edge per bit
      flash_serial_clock_o <= loading && sclk_phase;
      // data bit taken as the serial clock rises, after the flash launched it on the fall
      if (loading && sclk_phase && bit_cnt >= 16'h0020) begin
        cfg_shift <= {cfg_shift[6:0], flash_serial_in_i};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins, flag and configuration port

  // tri-state enables off and outputs inactive in reset, active after
  always_ff @(posedge clk_sys_i or posedge run_rst) begin
    if (run_rst) begin
      mirror_power_enable_oe_n_o <= 1'b1;
      led_oe_n_o                 <= 1'b1;
      flash_oe_n_o               <= 1'b1;
      mirror_power_enable_o      <= 1'b0;
      led_driver_enable_o        <= 1'b0;
      led_select_0_o             <= 1'b0;
      led_select_1_o             <= 1'b0;
      init_flag_o                <= 1'b0;
      parked_o                   <= 1'b0;
    end else begin
      mirror_power_enable_oe_n_o <= 1'b0;
      led_oe_n_o                 <= 1'b0;
      flash_oe_n_o               <= 1'b0;
      mirror_power_enable_o      <= state != crs_pkg::CRS_ST_PARKED;
      led_driver_enable_o        <= state == crs_pkg::CRS_ST_RUN;
      led_select_0_o             <= cfg_word_o[0];
      led_select_1_o             <= cfg_word_o[1];
      init_flag_o                <= (state == crs_pkg::CRS_ST_RESET ||
                                     state == crs_pkg::CRS_ST_PLL_WAIT ||
                                     state == crs_pkg::CRS_ST_FLASH_LOAD) ?
                                    crs_pkg::INIT_FLAG_BUSY : 1'b0;
      parked_o                   <= state == crs_pkg::CRS_ST_PARKED;
    end
  end

  // configuration register: loaded from flash, then written by host
  always_ff @(posedge clk_sys_i or posedge run_rst) begin
    if (run_rst) begin
      cfg_word_o  <= 8'h00;
      cfg_ready_o <= 1'b0;
    end else begin
      // follows next state so ready stands exactly while strobes are taken
      cfg_ready_o <= next_state == crs_pkg::CRS_ST_RUN;
      if (state == crs_pkg::CRS_ST_FLASH_LOAD && load_done) begin
        cfg_word_o <= cfg_shift;
      end else if (i2c_cfg_strobe_i && state == crs_pkg::CRS_ST_RUN) begin
        cfg_word_o <= i2c_cfg_data_i;
      end
    end
  end

endmodule
